// File: src/dacq_pkg.sv
// Package of offsets, field positions, reset values and timing for the acquisition card logic.
package dacq_pkg;

    // Register offsets within the eight-byte window.
    localparam logic [2:0] OFS_RESULT_LOW  = 3'h0;
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
    localparam logic [2:0] OFS_DAC1_LOW    = 3'h2;
    localparam logic [2:0] OFS_DAC1_HIGH   = 3'h3;
    localparam logic [2:0] OFS_UPDATE      = 3'h4;
    localparam logic [2:0] OFS_CONTROL     = 3'h5;
    localparam logic [2:0] OFS_DIGITAL     = 3'h7;

    // Control byte fields.
    localparam int CTL_RANGE_BIT = 4;
    localparam int CTL_BIP_BIT   = 3;
    localparam int CTL_CHAN_MSB  = 2;
    localparam int STAT_DONE_BIT = 7;

    // Reset values.
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [11:0] RST_WORD   = 12'h000;
    localparam logic [2:0]  RST_CHAN   = 3'h0;

    // Value returned for offsets with no readable register.
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Conversion time: 10 us at 250 MHz (100 kHz throughput).
    localparam int CLK_MHZ       = 250;
    localparam int CONV_TIME_NS  = 10000;
    localparam int CONV_CYCLES   = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CNT_W    = $clog2(CONV_CYCLES + 1);

    typedef enum logic [1:0] {
        DACQ_IDLE = 2'b00,
        DACQ_CONV = 2'b01,
        DACQ_DONE = 2'b11
    } dacq_state_e;

endpackage : dacq_pkg

// File: src/dacq_conv_timer.sv
// Conversion timer: counts one conversion period and restarts on every start pulse.
`timescale 1ns/10ps
module dacq_conv_timer (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        start,
    output logic                             finish
);
    import dacq_pkg::*;

    localparam logic [CONV_CNT_W-1:0] LOAD = CONV_CNT_W'(CONV_CYCLES);
    localparam logic [CONV_CNT_W-1:0] ONE  = CONV_CNT_W'(1);

    logic [CONV_CNT_W-1:0] count;
    wire                   running = (count != '0);

    // A fresh start reloads the count, so an earlier conversion is simply dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count  <= '0;
            finish <= 1'b0;
        end else begin
            finish <= running && (count == ONE) && !start;
            if (start) begin
                count <= LOAD;
            end else if (running) begin
                count <= count - ONE;
            end
        end
    end

endmodule : dacq_conv_timer

// File: src/dacq_card.sv
// Register-level logic of the acquisition card: converter control, output latches, digital ports.
`timescale 1ns/10ps

// Overview of operation
// [R1] Control byte write latches channel and range and starts a conversion.
// [R2] Host writes control bits 7..5 as 0,1,0.
// [R3] Bits 4 and 3 select span: 0-5, 0-10, +-5, +-10 volts.
// [R4] Bits 2..0 select one of eight input channels.
// [R5] Finished conversion drives status bit 7 to zero.
// [R6] Host waits for flag zero before reading the result bytes.
// [R7] Reading either result byte sets the completion flag back to one.
// [R8] Control write during conversion aborts it and starts a new one.
// [R9] Status bits 6..0 always read zero.
// [R10] Result is binary when unipolar, two's complement when bipolar.
// [R11] Result low register returns result bits 7..0.
// [R12] High register: bits 11..8 low, upper nibble zero or sign copy.
// [R13] Each output latch is 12 bits written as low and high bytes.
// [R14] Latch writes leave both analog outputs unchanged.
// [R15] Any write to update register loads both converters together.
// [R16] Digital input read returns current input pin levels.
// [R17] Digital output write drives the byte onto output pins.
// [R18] Eight consecutive byte offsets decoded as the port map gives.
// [R19] Seven switches weigh 200H..8H; eighth switch enables the card.
// [R20] After reset flag reads one and no conversion runs.
// [R21] Reads at unreadable offsets return a constant, no side effects.
module dacq_card (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [9:0]           io_addr,
    input  wire logic                 io_rd,
    input  wire logic                 io_wr,
    input  wire logic [7:0]           io_wdata,
    output logic      [7:0]           io_rdata,
    output logic                      io_rdata_en,
    input  wire logic [6:0]           base_address_switches,
    input  wire logic                 card_enable_n,
    input  wire logic [11:0]          adc_sample,
    output logic                      adc_start,
    output logic      [2:0]           channel_select,
    output logic                      span_ten_volt_select,
    output logic                      bipolar_select,
    output logic      [11:0]          dac_zero_code,
    output logic      [11:0]          dac_one_code,
    input  wire logic [7:0]           digital_in,
    output logic      [7:0]           digital_out
);
    import dacq_pkg::*;

    // Reset release through two flops.
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Address decode. Switch ON gives weight zero, so a set switch bit means OFF.
    // A disabled card answers nothing and changes nothing.
    wire       card_on   = !card_enable_n;                                  // R19
    wire       base_hit  = (io_addr[9:3] == base_address_switches);         // R19
    wire       selected  = card_on && base_hit;                             // R18
    wire [2:0] offset    = io_addr[2:0];

    // Access strobes are taken on their rising edge so a held strobe acts once.
    logic rd_prev;
    logic wr_prev;
    wire  rd_go = io_rd && !rd_prev && selected;
    wire  wr_go = io_wr && !wr_prev && selected;

    wire wr_control   = wr_go && (offset == OFS_CONTROL);                   // R1
    wire wr_dac0_low  = wr_go && (offset == OFS_RESULT_LOW);                // R13
    wire wr_dac0_high = wr_go && (offset == OFS_RESULT_HIGH);               // R13
    wire wr_dac1_low  = wr_go && (offset == OFS_DAC1_LOW);                  // R13
    wire wr_dac1_high = wr_go && (offset == OFS_DAC1_HIGH);                 // R13
    wire wr_update    = wr_go && (offset == OFS_UPDATE);                    // R15
    wire wr_digital   = wr_go && (offset == OFS_DIGITAL);                   // R17
    wire rd_result    = rd_go && ((offset == OFS_RESULT_LOW) ||
                                  (offset == OFS_RESULT_HIGH));             // R7

    // Control state.
    logic [2:0]  chan_q;
    logic        range_q;
    logic        bip_q;
    logic [11:0] result;
    logic        done_n;
    logic [7:0]  dac0_low;
    logic [3:0]  dac0_high;
    logic [7:0]  dac1_low;
    logic [3:0]  dac1_high;
    dacq_state_e state;
    dacq_state_e next_state;
    logic        conv_finish;

    dacq_conv_timer u_timer (
        .clk    (clk),
        .rst_n  (rst_sync_n),
        .start  (wr_control),
        .finish (conv_finish)
    );

    // Conversion sequence. A new control write always restarts it.
    always_comb begin
        next_state = state;
        case (state)
            DACQ_IDLE: begin
                if (wr_control) begin
                    next_state = DACQ_CONV;                                 // R1
                end
            end
            DACQ_CONV: begin
                if (wr_control) begin
                    next_state = DACQ_CONV;                                 // R8
                end else if (conv_finish) begin
                    next_state = DACQ_DONE;
                end
            end
            DACQ_DONE: begin
                if (wr_control) begin
                    next_state = DACQ_CONV;
                end else if (rd_result) begin
                    next_state = DACQ_IDLE;
                end
            end
            default: next_state = DACQ_IDLE;
        endcase
    end

    wire sample_now = (state == DACQ_CONV) && conv_finish && !wr_control;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state   <= DACQ_IDLE;                                           // R20
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end else begin
            state   <= next_state;
            rd_prev <= io_rd;
            wr_prev <= io_wr;
        end
    end

    // Completion flag: active low, set by the finish, returned high by a result read.
    // A finish coinciding with a result read wins, so a fresh sample is not hidden.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_n <= 1'b1;                                                 // R20
        end else if (sample_now) begin
            done_n <= 1'b0;                                                 // R5
        end else if (rd_result || wr_control) begin
            done_n <= 1'b1;                                                 // R7
        end
    end

    // The converter delivers binary or two's complement per the bipolar bit.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result <= RST_WORD;
        end else if (sample_now) begin
            result <= adc_sample;                                           // R10
        end
    end

    // Settings latched on every control write; bits 7..5 are assumed correct.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chan_q  <= RST_CHAN;
            range_q <= 1'b0;
            bip_q   <= 1'b0;
        end else if (wr_control) begin
            chan_q  <= io_wdata[CTL_CHAN_MSB:0];                            // R4
            range_q <= io_wdata[CTL_RANGE_BIT];                             // R3
            bip_q   <= io_wdata[CTL_BIP_BIT];                               // R3
        end
    end

    // Converter-side outputs.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            adc_start            <= 1'b0;
            channel_select       <= RST_CHAN;
            span_ten_volt_select <= 1'b0;
            bipolar_select       <= 1'b0;
        end else begin
            adc_start            <= wr_control;                             // R1
            channel_select       <= wr_control ? io_wdata[CTL_CHAN_MSB:0] : chan_q;
            span_ten_volt_select <= wr_control ? io_wdata[CTL_RANGE_BIT] : range_q;
            bipolar_select       <= wr_control ? io_wdata[CTL_BIP_BIT] : bip_q;
        end
    end

    // Input latches: writing them never touches the converter codes.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dac0_low  <= RST_BYTE;
            dac0_high <= 4'h0;
            dac1_low  <= RST_BYTE;
            dac1_high <= 4'h0;
        end else begin
            if (wr_dac0_low) begin
                dac0_low <= io_wdata;                                       // R14
            end
            if (wr_dac0_high) begin
                dac0_high <= io_wdata[3:0];                                 // R13
            end
            if (wr_dac1_low) begin
                dac1_low <= io_wdata;                                       // R14
            end
            if (wr_dac1_high) begin
                dac1_high <= io_wdata[3:0];                                 // R13
            end
        end
    end

    // Both codes load in the same cycle; the written value itself is ignored.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dac_zero_code <= RST_WORD;
            dac_one_code  <= RST_WORD;
        end else if (wr_update) begin
            dac_zero_code <= {dac0_high, dac0_low};                         // R15
            dac_one_code  <= {dac1_high, dac1_low};                         // R15
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            digital_out <= RST_BYTE;
        end else if (wr_digital) begin
            digital_out <= io_wdata;                                        // R17
        end
    end

    // Read multiplexer.
    wire [3:0] high_fill   = bip_q ? {4{result[11]}} : 4'h0;                // R12
    wire [7:0] status_byte = {done_n, 7'h00};                               // R9
    logic [7:0] next_rdata;
    logic       next_rdata_en;

    always_comb begin
        next_rdata    = READ_IDLE;
        next_rdata_en = 1'b0;
        if (selected && io_rd) begin
            case (offset)
                OFS_RESULT_LOW: begin
                    next_rdata    = result[7:0];                            // R11
                    next_rdata_en = 1'b1;
                end
                OFS_RESULT_HIGH: begin
                    next_rdata    = {high_fill, result[11:8]};              // R12
                    next_rdata_en = 1'b1;
                end
                OFS_CONTROL: begin
                    next_rdata    = status_byte;                            // R5
                    next_rdata_en = 1'b1;
                end
                OFS_DIGITAL: begin
                    next_rdata    = digital_in;                             // R16
                    next_rdata_en = 1'b1;
                end
                default: begin
                    next_rdata    = READ_IDLE;                              // R21
                    next_rdata_en = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            io_rdata    <= READ_IDLE;
            io_rdata_en <= 1'b0;
        end else begin
            io_rdata    <= next_rdata;
            io_rdata_en <= next_rdata_en;
        end
    end

endmodule : dacq_card

// File: bench/dacq_card_props.sv
// Checker of port timing for the acquisition card.
`timescale 1ns/10ps
module dacq_card_props
    import dacq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [9:0]  io_addr,
    input wire logic        io_rd,
    input wire logic        io_wr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_en,
    input wire logic [6:0]  base_address_switches,
    input wire logic        card_enable_n,
    input wire logic        adc_start,
    input wire logic [2:0]  channel_select,
    input wire logic        span_ten_volt_select,
    input wire logic        bipolar_select,
    input wire logic [11:0] dac_zero_code,
    input wire logic [11:0] dac_one_code,
    input wire logic [7:0]  digital_in,
    input wire logic [7:0]  digital_out
);
    logic wr_q;
    logic rd_q;
    // Strobes act once, so only the rising cycle counts as an access.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= io_wr;
            rd_q <= io_rd;
        end
    end
    wire       sel     = !card_enable_n && (io_addr[9:3] == base_address_switches);
    wire       wr_rise = io_wr && !wr_q && sel;
    wire       rd_rise = io_rd && !rd_q && sel;
    wire [2:0] ofs     = io_addr[2:0];

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence ctl_wr_s;
        wr_rise && ofs == OFS_CONTROL;
    endsequence
    sequence stat_rd_s;
        rd_rise && ofs == OFS_CONTROL;
    endsequence

    AST_START: assert property (ctl_wr_s |=> adc_start)
        else $error("no start after control write");
    AST_CHAN: assert property (ctl_wr_s |=> channel_select == $past(io_wdata[2:0]))
        else $error("channel not taken");
    AST_SPAN: assert property (ctl_wr_s |=>
        {span_ten_volt_select, bipolar_select} == $past(io_wdata[4:3]))
        else $error("span not taken");
    AST_PULSE: assert property (adc_start |=> !adc_start)
        else $error("start longer than one cycle");
    AST_STAT: assert property (stat_rd_s |=> io_rdata_en && io_rdata[6:0] == 7'h00)
        else $error("status low bits not zero");
    AST_FLAG_BUSY: assert property (ctl_wr_s ##[2:20] stat_rd_s |=> io_rdata[7])
        else $error("flag low right after control write");
    AST_OFF: assert property (card_enable_n && io_wr && !wr_q |=>
        !adc_start && $stable(digital_out))
        else $error("disabled card reacted");
    AST_DIN: assert property (rd_rise && ofs == OFS_DIGITAL |=>
        io_rdata_en && io_rdata == $past(digital_in))
        else $error("digital input read wrong");
    AST_DOUT: assert property (wr_rise && ofs == OFS_DIGITAL |=>
        digital_out == $past(io_wdata))
        else $error("digital output not written");
    AST_UNREAD: assert property (rd_rise && ofs inside {3'h2, 3'h3, 3'h4, 3'h6} |=>
        !io_rdata_en)
        else $error("unreadable offset driven");
    AST_DAC_HOLD: assert property (!(wr_rise && ofs == OFS_UPDATE) |=>
        $stable(dac_zero_code) && $stable(dac_one_code))
        else $error("converter code moved without update");
endmodule : dacq_card_props

bind dacq_card dacq_card_props chk_u (.clk, .rst_n, .io_addr, .io_rd, .io_wr, .io_wdata,
    .io_rdata, .io_rdata_en, .base_address_switches, .card_enable_n, .adc_start,
    .channel_select, .span_ten_volt_select, .bipolar_select, .dac_zero_code,
    .dac_one_code, .digital_in, .digital_out);

// File: bench/dacq_adc_model.sv
// Converter model: presents the code chosen by the bench once a conversion starts.
`timescale 1ns/10ps
module dacq_adc_model (
    input  wire logic        clk,
    input  wire logic        adc_start,
    input  wire logic [11:0] adc_pick,
    output logic      [11:0] adc_sample
);
    always_ff @(posedge clk) begin
        if (adc_start) begin
            adc_sample <= adc_pick;
        end
    end
endmodule : dacq_adc_model

// File: bench/tb_dacq_card.sv
// Self-checking bench of the acquisition card.
`timescale 1ns/10ps
module tb_dacq_card;
    import dacq_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  io_addr = 10'h000;
    logic        io_rd = 1'b0;
    logic        io_wr = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [6:0]  base_address_switches = 7'h00;
    logic        card_enable_n = 1'b0;
    logic [7:0]  digital_in = 8'h00;
    logic [11:0] adc_pick = 12'h000;
    logic [31:0] seed = 32'h0000001b;
    logic [6:0]  ab = 7'h00;
    logic [11:0] d0 = 12'h000;
    logic [11:0] d1 = 12'h000;
    logic [7:0]  io_rdata, digital_out;
    logic        io_rdata_en, adc_start, span_ten_volt_select, bipolar_select;
    logic [2:0]  channel_select;
    logic [11:0] adc_sample, dac_zero_code, dac_one_code;
    int          fails = 0;
    int          check_count = 0;
    int          cyc = 0;
    localparam logic [2:0] UR [4] = '{3'h2, 3'h3, 3'h4, 3'h6};

    always #2 clk = ~clk;

    dacq_card dut_u (.clk, .rst_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
        .io_rdata_en, .base_address_switches, .card_enable_n, .adc_sample, .adc_start,
        .channel_select, .span_ten_volt_select, .bipolar_select, .dac_zero_code,
        .dac_one_code, .digital_in, .digital_out);
    dacq_adc_model adc_u (.clk, .adc_start, .adc_pick, .adc_sample);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic stop_test();
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // The strobe is dropped half a cycle after it is taken, so the next access sees it low.
    task automatic wr(input logic [2:0] o, input logic [7:0] d);
        @(negedge clk);
        io_addr = {ab, o};
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [2:0] o, output logic [7:0] d, output logic e);
        @(negedge clk);
        io_addr = {ab, o};
        io_rd = 1'b1;
        repeat (2) @(negedge clk);
        d = io_rdata;
        e = io_rdata_en;
        io_rd = 1'b0;
    endtask : rd

    // One conversion; the long form checks a restarted conversion is not cut short.
    task automatic conv(input logic [7:0] ctl, input bit lng);
        logic [31:0] r;
        logic [7:0]  d;
        logic        e;
        int          n;
        logic [7:0]  exp_q [$];
        r = rnd();
        adc_pick = r[11:0];
        exp_q.push_back(r[7:0]);
        exp_q.push_back({ctl[3] ? {4{r[11]}} : 4'h0, r[11:8]});
        wr(OFS_CONTROL, ctl);
        chk({span_ten_volt_select, bipolar_select, channel_select}, ctl[4:0]);
        if (lng) begin
            repeat (2440) @(negedge clk);
        end
        rd(OFS_CONTROL, d, e);
        chk(d, 8'h80);
        n = 0;
        while (d[7] && n < 1000) begin
            rd(OFS_CONTROL, d, e);
            n++;
        end
        chk(d, 8'h00);
        rd(OFS_RESULT_LOW, d, e);
        chk(d, exp_q.pop_front());
        rd(OFS_RESULT_HIGH, d, e);
        chk(d, exp_q.pop_front());
        rd(OFS_CONTROL, d, e);
        chk(d, 8'h80);
    endtask : conv

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            stop_test();
        end
    end

    initial begin : main
        logic [31:0] r;
        logic [7:0]  d;
        logic        e;
        r = rnd();
        base_address_switches = r[6:0];
        ab = r[6:0];
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(OFS_CONTROL, d, e);
        chk(d, 8'h80);
        for (int i = 0; i < 4; i++) begin
            rd(UR[i], d, e);
            chk(e, 1'b0);
            chk(d, READ_IDLE);
        end
        for (int m = 0; m < 4; m++) begin
            r = rnd();
            conv({3'b010, m[1:0], r[2:0]}, 1'b0);
        end
        wr(OFS_CONTROL, 8'h47);
        repeat (100) @(negedge clk);
        conv(8'h5a, 1'b1);
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            wr(3'h0, r[7:0]);
            wr(3'h1, {4'h0, r[11:8]});
            wr(OFS_DAC1_LOW, r[19:12]);
            wr(OFS_DAC1_HIGH, {4'h0, r[23:20]});
            chk(dac_zero_code, d0);
            chk(dac_one_code, d1);
            wr(OFS_UPDATE, r[31:24]);
            d0 = r[11:0];
            d1 = r[23:12];
            chk(dac_zero_code, d0);
            chk(dac_one_code, d1);
        end
        // A reset in mid-conversion must leave the flag high and the codes cleared.
        wr(OFS_CONTROL, 8'h52);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        d0 = RST_WORD;
        d1 = RST_WORD;
        repeat (2600) @(negedge clk);
        rd(OFS_CONTROL, d, e);
        chk(d, 8'h80);
        chk(dac_zero_code, d0);
        chk(dac_one_code, d1);
        r = rnd();
        digital_in = r[7:0];
        rd(OFS_DIGITAL, d, e);
        chk(d, r[7:0]);
        wr(OFS_DIGITAL, r[15:8]);
        chk(digital_out, r[15:8]);
        card_enable_n = 1'b1;
        wr(OFS_DIGITAL, ~r[15:8]);
        chk(digital_out, r[15:8]);
        rd(OFS_DIGITAL, d, e);
        chk(e, 1'b0);
        wr(OFS_CONTROL, 8'h40);
        card_enable_n = 1'b0;
        ab = ab ^ 7'h01;
        wr(OFS_DIGITAL, ~r[15:8]);
        chk(digital_out, r[15:8]);
        stop_test();
    end
endmodule : tb_dacq_card
